// ===== logic/rcsp_map.svh
`ifndef RCSP_MAP_SVH
`define RCSP_MAP_SVH

// ==================================================
// Control byte field positions
`define RCSP_CB_LOCK 0
`define RCSP_CB_SEL_LO 1
`define RCSP_CB_SEL_HI 4
`define RCSP_CB_PROG_SEL_1 2
`define RCSP_CB_SAVE 5
`define RCSP_CB_TRIG 6
`define RCSP_CB_CLEAR 7

// ==================================================
// Status byte field positions
`define RCSP_SB_IN_SERVICE 0
`define RCSP_SB_PROG_STORED 1
`define RCSP_SB_RUN_READY 2
`define RCSP_SB_DECODED 3
`define RCSP_SB_MATCH 4
`define RCSP_SB_UNREAD 5

// ==================================================
// Send area byte layout
`define RCSP_SA_SEQ 1
`define RCSP_SA_LEN_HI 2
`define RCSP_SA_LEN_LO 3
`define RCSP_SA_ID 4
`define RCSP_SA_USER 5
`define RCSP_SA_BYTES 32
`define RCSP_SA_USER_BYTES 27
`define RCSP_SA_LAST_USER 5'h1a

// ==================================================
// Reset values
`define RCSP_RST_CTRL 8'h00
`define RCSP_RST_STATUS 8'h00
`define RCSP_RST_PROG 4'h0
`define RCSP_RST_SEQ 8'h00
`define RCSP_NO_DATA_ID 8'h00

`endif

// ===== logic/rcsp_pkg.sv
package rcsp_pkg;

    // ==================================================
    // Reader operating mode
    typedef enum logic [2:0] {
        ST_STARTUP = 3'b000,
        ST_RUN = 3'b001,
        ST_STOP = 3'b010,
        ST_ERROR = 3'b011,
        ST_IDENT = 3'b100,
        ST_RESUME = 3'b101
    } rcsp_mode_t;

    // ==================================================
    // Connection choice for each configurable option
    typedef enum logic [1:0] {
        CONN_LOCAL = 2'b00,
        CONN_SERIAL = 2'b01,
        CONN_FIELDBUS = 2'b10,
        CONN_NONE = 2'b11
    } rcsp_conn_t;

    // ==================================================
    // Send area packer
    typedef enum logic [1:0] {
        PK_IDLE = 2'b00,
        PK_FILL = 2'b01,
        PK_OFFER = 2'b10,
        PK_DROP = 2'b11
    } rcsp_pack_t;

endpackage : rcsp_pkg

// ===== logic/rcsp_buf.sv
`timescale 1ns/1ps

// ==================================================
// Two-entry buffer; ready and valid come from flops
module rcsp_buf #(
    parameter int WIDTH = 9
) (
    input wire logic clk_i, // System clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic [WIDTH-1:0] in_data_i, // Write data
    input wire logic in_valid_i, // Write request
    output logic in_ready_o, // Room for a word
    output logic [WIDTH-1:0] out_data_o, // Head word
    output logic out_valid_o, // Head word present
    input wire logic out_ready_i // Head word taken
);

    logic [WIDTH-1:0] mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic room;
    logic empty;
    wire full = ~room;

    wire push = in_valid_i & ~full;
    wire pop = out_ready_i & ~empty;
    wire next_full = (full & ~pop) | (~empty & push & ~pop);
    wire next_empty = (empty & ~push) | (~full & pop & ~push);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            room <= 1'b1;
            empty <= 1'b1;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            room <= ~next_full;
            empty <= next_empty;
        end
    end

    // Storage needs no reset; the empty flag masks it
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    assign in_ready_o = room;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[rd_ptr];

endmodule : rcsp_buf

// ===== logic/rcsp_top.sv
`timescale 1ns/1ps
`include "rcsp_map.svh"

// What this block does
// - Input lock blocks local keypad, program select, save, acknowledge and start.
// - Control bits 1..4 form program number, bit 1 least significant.
// - Bit 2 selects program bit 1, or commands save while save request set.
// - Save request stores the currently selected program.
// - Trigger rising edge starts processing; error clear clears pending error.
// - Program select and save request act only while input lock is set.
// - In service reads 0 during error, 1 when working without error.
// - In run, program stored tells whether selected program was saved.
// - During save, program stored 0 while busy, then 1 with run ready 0.
// - Run ready is 0 in startup or stop, 1 in run unless save request set.
// - Status bits 3..5 give decoded, match, unreadable; bits 6, 7 zero.
// - First init bit presents the identifying error code.
// - Second init acknowledges; device resumes with in service and run ready.
// - Resume sets input lock automatically, then drops it unless manually set.
// - Acknowledge accepted only from the configured controlling connection.
// - Serial host reachable only if some option selects it.
// - Send byte 1 holds packet sequence number; byte 0 reserved.
// - Send bytes 2, 3 hold total net length, 16 bits.
// - Send byte 4 echoes the data identifier being transferred.
module rcsp_top import rcsp_pkg::*; (
    input wire logic MCLK_I, // System clock, 200 MHz
    input wire logic ARST_N_I, // Async reset, active low
    input wire logic [7:0] CTRL_BYTE_I, // Cyclic control byte
    input wire logic CTRL_VALID_I, // Control byte update strobe
    output logic [7:0] STATUS_BYTE_O, // Cyclic status byte
    input wire logic FB_INIT_I, // Fieldbus initialisation bit
    input wire logic SH_INIT_I, // Serial host initialisation bit
    output logic [7:0] ERR_CODE_O, // Identified group error code
    input wire logic [7:0] RX_SEQ_I, // Receive area byte 1
    input wire logic [7:0] RX_ID_I, // Receive area byte 4
    input wire logic RX_VALID_I, // Receive area update strobe
    output logic [255:0] SEND_AREA_O, // Send area, byte 0 in bits 7:0
    output logic SEND_VALID_O, // A packet is on offer
    input wire logic [7:0] RES_DATA_I, // Result data byte
    input wire logic RES_LAST_I, // Last byte of the result
    input wire logic RES_VALID_I, // Result byte valid
    output logic RES_READY_O, // Result byte accepted
    input wire logic [15:0] RES_LEN_I, // Total net result length
    input wire logic [1:0] CFG_TRIG_SRC_I, // Trigger source connection
    input wire logic [1:0] CFG_RESULT_I, // Binary result connection
    input wire logic [1:0] CFG_RSTRING_I, // Result string connection
    input wire logic [1:0] CFG_CONTROL_I, // Controlling connection
    input wire logic CORE_UP_I, // Reader startup finished
    input wire logic CORE_STOP_I, // Reader stopped
    input wire logic CORE_ERR_I, // Group error event pulse
    input wire logic [7:0] CORE_ERR_CODE_I, // Code of that error
    input wire logic SAVE_DONE_I, // Program save finished pulse
    input wire logic [2:0] RES_FLAGS_I, // Decoded, match, unreadable
    input wire logic RES_FLAGS_STB_I, // Result flags strobe
    input wire logic [3:0] LOC_PROG_I, // Keypad program number pins
    input wire logic LOC_TAKE_I, // Keypad program select pin
    input wire logic LOC_SAVE_I, // Keypad save pin
    input wire logic LOC_ACK_I, // Keypad error acknowledge pin
    input wire logic LOC_START_I, // Keypad start pin
    output logic [3:0] PROG_NUM_O, // Selected program number
    output logic SAVE_CMD_O, // Save program pulse
    output logic TRIGGER_O, // Start processing pulse
    output logic INPUT_LOCK_O, // Effective input lock
    output logic SERIAL_EN_O // Serial host interface enabled
);

    // ==================================================
    // Keypad pin synchronisers
    wire [7:0] loc_pins = {LOC_START_I, LOC_ACK_I, LOC_SAVE_I, LOC_TAKE_I, LOC_PROG_I};
    logic [7:0] loc_meta;
    logic [7:0] loc_sync;
    logic [7:0] loc_prev;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_sync
            always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    loc_meta[g] <= 1'b0;
                    loc_sync[g] <= 1'b0;
                    loc_prev[g] <= 1'b0;
                end else begin
                    loc_meta[g] <= loc_pins[g];
                    loc_sync[g] <= loc_meta[g];
                    loc_prev[g] <= loc_sync[g];
                end
            end
        end
    endgenerate

    wire [7:0] loc_rise = loc_sync & ~loc_prev;

    // ==================================================
    // Control byte and edge detection
    logic [7:0] ctrl_q;
    logic auto_lock;
    logic fb_init_q;
    logic sh_init_q;
    rcsp_mode_t mode;
    rcsp_mode_t next_mode;

    wire [7:0] fb_rise = {8{CTRL_VALID_I}} & CTRL_BYTE_I & ~ctrl_q;
    wire eff_lock = ctrl_q[`RCSP_CB_LOCK] | auto_lock;
    wire new_lock = CTRL_BYTE_I[`RCSP_CB_LOCK];
    wire new_save = CTRL_BYTE_I[`RCSP_CB_SAVE];
    wire save_req = ctrl_q[`RCSP_CB_LOCK] & ctrl_q[`RCSP_CB_SAVE];

    wire fb_ctrl = (CFG_CONTROL_I == CONN_FIELDBUS);
    wire sh_ctrl = (CFG_CONTROL_I == CONN_SERIAL);
    wire loc_ctrl = (CFG_CONTROL_I == CONN_LOCAL);
    wire serial_any = (CFG_TRIG_SRC_I == CONN_SERIAL) | (CFG_RESULT_I == CONN_SERIAL) |
                      (CFG_RSTRING_I == CONN_SERIAL) | sh_ctrl;

    // Init is a level from the controller; only its rising edge counts
    wire fb_init_rise = FB_INIT_I & ~fb_init_q;
    wire sh_init_rise = SH_INIT_I & ~sh_init_q;
    wire init_ok = (fb_init_rise & fb_ctrl) | (sh_init_rise & sh_ctrl & serial_any);
    wire clear_ok = (fb_rise[`RCSP_CB_CLEAR] & fb_ctrl) |
                    (loc_rise[6] & ~eff_lock & loc_ctrl);

    // ==================================================
    // Program selection and save
    wire fb_sel = CTRL_VALID_I & new_lock & ~new_save;
    wire fb_save = fb_rise[`RCSP_CB_PROG_SEL_1] & new_lock & new_save;
    wire loc_sel = loc_rise[4] & ~eff_lock;
    wire loc_save = loc_rise[5] & ~eff_lock;
    wire save_go = fb_save | loc_save;

    wire in_run = (mode == ST_RUN);
    wire fb_trig = fb_rise[`RCSP_CB_TRIG] & (CFG_TRIG_SRC_I == CONN_FIELDBUS);
    wire loc_trig = loc_rise[7] & ~eff_lock & (CFG_TRIG_SRC_I == CONN_LOCAL);
    wire trig_go = in_run & (fb_trig | loc_trig);

    logic [3:0] prog_num;
    logic [15:0] saved_map;
    logic saving;
    logic save_ack;
    logic [2:0] res_flags;
    logic [7:0] err_code;

    wire [3:0] next_prog = fb_sel ? CTRL_BYTE_I[`RCSP_CB_SEL_HI:`RCSP_CB_SEL_LO] : loc_sync[3:0];
    wire prog_go = fb_sel | loc_sel;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_q <= `RCSP_RST_CTRL;
            fb_init_q <= 1'b0;
            sh_init_q <= 1'b0;
            prog_num <= `RCSP_RST_PROG;
        end else begin
            if (CTRL_VALID_I) begin
                ctrl_q <= CTRL_BYTE_I;
            end
            fb_init_q <= FB_INIT_I;
            sh_init_q <= SH_INIT_I;
            if (prog_go) begin
                prog_num <= next_prog;
            end
        end
    end

    // Save busy clears on done, but a new command in the same cycle wins
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            saving <= 1'b0;
            save_ack <= 1'b0;
            saved_map <= 16'h0000;
        end else begin
            saving <= save_go | (saving & ~SAVE_DONE_I);
            save_ack <= (save_ack & save_req & ~save_go) | (SAVE_DONE_I & saving);
            if (SAVE_DONE_I & saving) begin
                saved_map[prog_num] <= 1'b1;
            end
        end
    end

    // Flags clear on a new trigger; a strobe in the same cycle wins
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            res_flags <= 3'h0;
        end else if (RES_FLAGS_STB_I) begin
            res_flags <= RES_FLAGS_I;
        end else if (trig_go) begin
            res_flags <= 3'h0;
        end
    end

    // ==================================================
    // Operating mode and group error handling
    always_comb begin
        next_mode = mode;
        unique case (mode)
            ST_STARTUP: if (CORE_ERR_I) next_mode = ST_ERROR;
                else if (CORE_UP_I) next_mode = CORE_STOP_I ? ST_STOP : ST_RUN;
            ST_RUN: if (CORE_ERR_I) next_mode = ST_ERROR;
                else if (CORE_STOP_I) next_mode = ST_STOP;
            ST_STOP: if (CORE_ERR_I) next_mode = ST_ERROR;
                else if (!CORE_STOP_I) next_mode = ST_RUN;
            ST_ERROR: if (init_ok) next_mode = ST_IDENT;
                else if (clear_ok) next_mode = ST_RESUME;
            ST_IDENT: if (init_ok | clear_ok) next_mode = ST_RESUME;
            ST_RESUME: next_mode = ST_RUN;
            default: next_mode = ST_STARTUP;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode <= ST_STARTUP;
            auto_lock <= 1'b0;
            err_code <= 8'h00;
        end else begin
            mode <= next_mode;
            auto_lock <= (next_mode == ST_RESUME);
            if (CORE_ERR_I & (mode != ST_ERROR) & (mode != ST_IDENT)) begin
                err_code <= CORE_ERR_CODE_I;
            end
        end
    end

    // ==================================================
    // Status byte and registered outputs
    wire in_service = (mode != ST_ERROR) & (mode != ST_IDENT);
    wire run_ready = in_run & ~save_req;
    wire prog_stored = save_req ? (save_ack & ~saving) : saved_map[prog_num];
    wire [7:0] next_status = {2'b00, res_flags, run_ready, prog_stored, in_service};

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            STATUS_BYTE_O <= `RCSP_RST_STATUS;
            ERR_CODE_O <= 8'h00;
            PROG_NUM_O <= `RCSP_RST_PROG;
            SAVE_CMD_O <= 1'b0;
            TRIGGER_O <= 1'b0;
            INPUT_LOCK_O <= 1'b0;
            SERIAL_EN_O <= 1'b0;
        end else begin
            STATUS_BYTE_O <= next_status;
            ERR_CODE_O <= (mode == ST_IDENT) ? err_code : 8'h00;
            PROG_NUM_O <= prog_num;
            SAVE_CMD_O <= save_go;
            TRIGGER_O <= trig_go;
            INPUT_LOCK_O <= eff_lock;
            SERIAL_EN_O <= serial_any;
        end
    end

    // ==================================================
    // Result buffer and send area packer
    logic [8:0] buf_data;
    logic buf_valid;
    rcsp_pack_t pk;
    wire buf_pop = buf_valid & ((pk == PK_FILL) | (pk == PK_DROP));

    rcsp_buf #(
        .WIDTH(9)
    ) u_buf (
        .clk_i(MCLK_I),
        .arst_n_i(ARST_N_I),
        .in_data_i({RES_LAST_I, RES_DATA_I}),
        .in_valid_i(RES_VALID_I),
        .in_ready_o(RES_READY_O),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop)
    );

    logic [215:0] stage;
    logic [4:0] idx;
    logic [7:0] seq;
    logic [7:0] cur_id;
    logic [15:0] tot_len;
    logic last_pkt;

    wire fill_done = buf_pop & (pk == PK_FILL) & (buf_data[8] | (idx == `RCSP_SA_LAST_USER));
    wire [7:0] next_seq = seq + 8'h01;
    wire seq_match = RX_VALID_I & (RX_SEQ_I == seq);
    wire [215:0] next_stage = stage | ({208'h0, buf_data[7:0]} << {idx, 3'b000});

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pk <= PK_IDLE;
            idx <= 5'h00;
            seq <= `RCSP_RST_SEQ;
            cur_id <= `RCSP_NO_DATA_ID;
            tot_len <= 16'h0000;
            last_pkt <= 1'b0;
            stage <= 216'h0;
            SEND_AREA_O <= 256'h0;
            SEND_VALID_O <= 1'b0;
        end else begin
            unique case (pk)
                PK_IDLE: if (buf_valid) begin
                    if (RX_ID_I == `RCSP_NO_DATA_ID) begin
                        pk <= PK_DROP; // No data ID: result is processed but not sent
                    end else begin
                        cur_id <= RX_ID_I;
                        tot_len <= RES_LEN_I;
                        stage <= 216'h0;
                        idx <= 5'h00;
                        pk <= PK_FILL;
                    end
                end
                PK_FILL: if (buf_pop) begin
                    stage <= next_stage;
                    idx <= idx + 5'h01;
                    if (fill_done) begin
                        seq <= next_seq;
                        last_pkt <= buf_data[8];
                        SEND_AREA_O <= {next_stage, cur_id, tot_len[7:0], tot_len[15:8], next_seq, 8'h00};
                        SEND_VALID_O <= 1'b1;
                        pk <= PK_OFFER;
                    end
                end
                PK_OFFER: if (seq_match) begin
                    SEND_VALID_O <= 1'b0;
                    stage <= 216'h0;
                    idx <= 5'h00;
                    pk <= last_pkt ? PK_IDLE : PK_FILL;
                end
                PK_DROP: if (buf_pop & buf_data[8]) begin
                    pk <= PK_IDLE;
                end
            endcase
        end
    end

endmodule : rcsp_top

// ===== dv/rcsp_top_monitor.sv
`timescale 1ns/1ps

// ==================================================
// Port checker for the control and status port
module rcsp_checker (
    input wire logic MCLK_I, // clock
    input wire logic ARST_N_I, // reset
    input wire logic [7:0] CTRL_BYTE_I, // control byte
    input wire logic CTRL_VALID_I, // control strobe
    input wire logic [7:0] STATUS_BYTE_O, // status byte
    input wire logic [7:0] ERR_CODE_O, // error code
    input wire logic [7:0] RX_SEQ_I, // receive seq
    input wire logic RX_VALID_I, // receive strobe
    input wire logic [255:0] SEND_AREA_O, // send area
    input wire logic SEND_VALID_O, // offer
    input wire logic [1:0] CFG_TRIG_SRC_I, // trigger conn
    input wire logic [1:0] CFG_RESULT_I, // result conn
    input wire logic [1:0] CFG_RSTRING_I, // string conn
    input wire logic [1:0] CFG_CONTROL_I, // control conn
    input wire logic TRIGGER_O, // start pulse
    input wire logic SAVE_CMD_O, // save pulse
    input wire logic SERIAL_EN_O // serial enable
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    logic ack;
    logic ser_any;
    assign ack = RX_VALID_I && RX_SEQ_I == SEND_AREA_O[15:8];
    assign ser_any = CFG_TRIG_SRC_I == 2'h1 || CFG_RESULT_I == 2'h1 || CFG_RSTRING_I == 2'h1 || CFG_CONTROL_I == 2'h1;

    status_reserved_a: assert property (STATUS_BYTE_O[7:6] == 2'h0)
        else $error("status reserved bits set");
    trigger_pulse_a: assert property (TRIGGER_O |=> !TRIGGER_O)
        else $error("trigger longer than one cycle");
    trigger_cause_a: assert property (TRIGGER_O && $past(CFG_TRIG_SRC_I) == 2'h2 |-> $past(CTRL_VALID_I && CTRL_BYTE_I[6]))
        else $error("trigger without control update");
    save_cause_a: assert property (SAVE_CMD_O && $past(CTRL_VALID_I) |-> $past(CTRL_BYTE_I[0] && CTRL_BYTE_I[5] && CTRL_BYTE_I[2]))
        else $error("save without lock and request");
    area_reserved_a: assert property (SEND_AREA_O[7:0] == 8'h00)
        else $error("send byte 0 not zero");
    seq_step_a: assert property ($rose(SEND_VALID_O) |-> SEND_AREA_O[15:8] == $past(SEND_AREA_O[15:8]) + 8'h01)
        else $error("sequence did not step by one");
    offer_hold_a: assert property (SEND_VALID_O && !ack |=> SEND_VALID_O && $stable(SEND_AREA_O))
        else $error("offer changed before acknowledge");
    offer_drop_a: assert property (SEND_VALID_O && ack |=> !SEND_VALID_O)
        else $error("offer kept after acknowledge");
    code_in_error_a: assert property (ERR_CODE_O != 8'h00 |-> !STATUS_BYTE_O[0])
        else $error("error code while in service");
    serial_enable_a: assert property (1'b1 |=> SERIAL_EN_O == $past(ser_any))
        else $error("serial enable wrong");

    cover property (TRIGGER_O);
    cover property ($rose(SEND_VALID_O));
    cover property (ERR_CODE_O != 8'h00);
endmodule : rcsp_checker

bind rcsp_top rcsp_checker mon (.*);

// ===== dv/rcsp_plc_model.sv
`timescale 1ns/1ps

// ==================================================
// I/O controller side of the cyclic exchange
module rcsp_plc_model (
    input wire logic clk_i, // clock
    input wire logic offer_i, // packet on offer
    input wire logic [7:0] offer_seq_i, // offered seq
    input wire logic [7:0] want_id_i, // data wanted
    input wire logic [3:0] lag_i, // reply delay
    output logic rx_valid_o, // receive update
    output logic [7:0] rx_seq_o, // last good seq
    output logic [7:0] rx_id_o // requested id
);
    int wait_cnt = 0;
    initial begin
        rx_valid_o = 1'b0;
        rx_seq_o = 8'h00;
        rx_id_o = 8'h00;
    end
    // Lag models a slow cyclic update; zero answers at once
    always @(posedge clk_i) begin
        rx_valid_o <= 1'b0;
        rx_id_o <= want_id_i;
        if (offer_i && !rx_valid_o) begin
            if (wait_cnt >= int'(lag_i)) begin
                rx_valid_o <= 1'b1;
                rx_seq_o <= offer_seq_i;
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule : rcsp_plc_model

// ===== dv/reader_control_status_port_test.sv
`timescale 1ns/1ps

module reader_control_status_port_test import rcsp_pkg::*;;
    logic MCLK_I, ARST_N_I, CTRL_VALID_I, FB_INIT_I, SH_INIT_I, RX_VALID_I, SEND_VALID_O;
    logic RES_LAST_I, RES_VALID_I, RES_READY_O, CORE_UP_I, CORE_STOP_I, CORE_ERR_I, SAVE_DONE_I;
    logic RES_FLAGS_STB_I, LOC_TAKE_I, LOC_SAVE_I, LOC_ACK_I, LOC_START_I, SAVE_CMD_O, TRIGGER_O;
    logic INPUT_LOCK_O, SERIAL_EN_O;
    logic [7:0] CTRL_BYTE_I, STATUS_BYTE_O, ERR_CODE_O, RX_SEQ_I, RX_ID_I, RES_DATA_I, CORE_ERR_CODE_I;
    logic [255:0] SEND_AREA_O;
    logic [15:0] RES_LEN_I;
    logic [1:0] CFG_TRIG_SRC_I, CFG_RESULT_I, CFG_RSTRING_I, CFG_CONTROL_I;
    logic [2:0] RES_FLAGS_I;
    logic [3:0] LOC_PROG_I, PROG_NUM_O;
    int failures = 0, n_compared = 0, n_trig = 0, n_save = 0, n_lock = 0, t0;

    rcsp_top dut (.*);
    rcsp_plc_model plc (.clk_i(MCLK_I), .offer_i(SEND_VALID_O), .offer_seq_i(SEND_AREA_O[15:8]),
        .want_id_i(8'h81), .lag_i(4'h5), .rx_valid_o(RX_VALID_I), .rx_seq_o(RX_SEQ_I), .rx_id_o(RX_ID_I));

    initial begin
        MCLK_I = 1'b0;
        forever #2.5 MCLK_I = ~MCLK_I;
    end
    always @(posedge MCLK_I) begin
        n_trig <= n_trig + int'(TRIGGER_O === 1'b1);
        n_save <= n_save + int'(SAVE_CMD_O === 1'b1);
        n_lock <= n_lock + int'(INPUT_LOCK_O === 1'b1);
    end

    // ==================================================
    // Shared tasks
    task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge MCLK_I);
        #1;
    endtask : step
    task automatic ctl(input logic [7:0] b);
        @(posedge MCLK_I);
        CTRL_BYTE_I <= b;
        CTRL_VALID_I <= 1'b1;
        @(posedge MCLK_I);
        CTRL_VALID_I <= 1'b0;
        step(3);
    endtask : ctl
    task automatic stream(input int n);
        @(posedge MCLK_I);
        for (int i = 1; i <= n; i++) begin
            RES_DATA_I <= 8'(i) ^ 8'ha0;
            RES_LAST_I <= 1'(i == n);
            RES_VALID_I <= 1'b1;
            #1;
            while (RES_READY_O !== 1'b1) step(1);
            @(posedge MCLK_I);
        end
        RES_VALID_I <= 1'b0;
    endtask : stream
    task automatic wait_offer(input logic [7:0] s);
        for (int k = 0; k < 300 && !(SEND_VALID_O === 1'b1 && SEND_AREA_O[15:8] === s); k++) step(1);
        chk("offer", {1'b1, s}, {SEND_VALID_O, SEND_AREA_O[15:8]});
    endtask : wait_offer

    // ==================================================
    // Scenarios
    task automatic t_startup();
        step(3);
        chk("status", 8'h01, STATUS_BYTE_O);
        chk("serial", 1'b0, SERIAL_EN_O);
        @(posedge MCLK_I) CFG_RESULT_I <= CONN_SERIAL;
        step(3);
        chk("serial", 1'b1, SERIAL_EN_O);
        @(posedge MCLK_I) CORE_UP_I <= 1'b1;
        step(4);
        chk("status", 8'h05, STATUS_BYTE_O);
        $display("t_startup done");
    endtask : t_startup
    task automatic t_prog();
        ctl(8'h1b);
        chk("program", 4'hd, PROG_NUM_O);
        ctl(8'h06);
        chk("program", 4'hd, PROG_NUM_O);
        ctl(8'h1b);
        @(posedge MCLK_I) LOC_PROG_I <= 4'h3;
        @(posedge MCLK_I) LOC_TAKE_I <= 1'b1;
        step(5);
        chk("program", 4'hd, PROG_NUM_O);
        $display("t_prog done");
    endtask : t_prog
    task automatic t_save();
        t0 = n_save;
        ctl(8'h3b);
        ctl(8'h3f);
        chk("save count", 1, n_save - t0);
        chk("status", 8'h01, STATUS_BYTE_O);
        @(posedge MCLK_I) SAVE_DONE_I <= 1'b1;
        @(posedge MCLK_I) SAVE_DONE_I <= 1'b0;
        step(3);
        chk("status", 8'h03, STATUS_BYTE_O);
        ctl(8'h1b);
        chk("status", 8'h07, STATUS_BYTE_O);
        $display("t_save done");
    endtask : t_save
    task automatic t_trig();
        t0 = n_trig;
        @(posedge MCLK_I) RES_FLAGS_I <= 3'h3;
        @(posedge MCLK_I) RES_FLAGS_STB_I <= 1'b1;
        @(posedge MCLK_I) RES_FLAGS_STB_I <= 1'b0;
        step(3);
        chk("status", 8'h1f, STATUS_BYTE_O);
        ctl(8'h5b);
        chk("status", 8'h07, STATUS_BYTE_O);
        ctl(8'h5b);
        @(posedge MCLK_I) CFG_TRIG_SRC_I <= CONN_LOCAL;
        ctl(8'h1b);
        ctl(8'h5b);
        chk("trigger count", 1, n_trig - t0);
        @(posedge MCLK_I) CFG_TRIG_SRC_I <= CONN_FIELDBUS;
        $display("t_trig done");
    endtask : t_trig
    task automatic t_error();
        ctl(8'h00);
        @(posedge MCLK_I) CORE_ERR_CODE_I <= 8'h5a;
        @(posedge MCLK_I) CORE_ERR_I <= 1'b1;
        @(posedge MCLK_I) CORE_ERR_I <= 1'b0;
        step(3);
        chk("in service", 1'b0, STATUS_BYTE_O[0]);
        @(posedge MCLK_I) FB_INIT_I <= 1'b1;
        step(4);
        chk("error code", 8'h00, ERR_CODE_O);
        @(posedge MCLK_I) FB_INIT_I <= 1'b0;
        @(posedge MCLK_I) CFG_CONTROL_I <= CONN_FIELDBUS;
        @(posedge MCLK_I) FB_INIT_I <= 1'b1;
        step(4);
        chk("error code", 8'h5a, ERR_CODE_O);
        @(posedge MCLK_I) FB_INIT_I <= 1'b0;
        t0 = n_lock;
        @(posedge MCLK_I) FB_INIT_I <= 1'b1;
        step(5);
        chk("auto lock cycles", 1, n_lock - t0);
        chk("status", 8'h07, STATUS_BYTE_O);
        @(posedge MCLK_I) FB_INIT_I <= 1'b0;
        $display("t_error done");
    endtask : t_error
    task automatic t_send();
        @(posedge MCLK_I) RES_LEN_I <= 16'h001e;
        fork
            stream(30);
            begin
                wait_offer(8'h01);
                chk("length", 16'h001e, {SEND_AREA_O[23:16], SEND_AREA_O[31:24]});
                chk("data id", 8'h81, SEND_AREA_O[39:32]);
                chk("user 1", 8'ha1, SEND_AREA_O[47:40]);
                chk("user 27", 8'hbb, SEND_AREA_O[255:248]);
                step(2);
                chk("stalled ready", 1'b0, RES_READY_O);
                wait_offer(8'h02);
                chk("user 1", 8'hbc, SEND_AREA_O[47:40]);
                chk("user 3", 8'hbe, SEND_AREA_O[63:56]);
                chk("user 4", 8'h00, SEND_AREA_O[71:64]);
            end
        join
        step(20);
        chk("offer", 1'b0, SEND_VALID_O);
        $display("t_send done");
    endtask : t_send

    task automatic close_out();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    initial begin
        ARST_N_I = 1'b0;
        {CTRL_VALID_I, FB_INIT_I, SH_INIT_I, RES_LAST_I, RES_VALID_I, CORE_UP_I, CORE_STOP_I, CORE_ERR_I,
            SAVE_DONE_I, RES_FLAGS_STB_I, LOC_TAKE_I, LOC_SAVE_I, LOC_ACK_I, LOC_START_I} = '0;
        {CTRL_BYTE_I, RES_DATA_I, CORE_ERR_CODE_I, RES_LEN_I, RES_FLAGS_I, LOC_PROG_I} = '0;
        {CFG_TRIG_SRC_I, CFG_RESULT_I, CFG_RSTRING_I, CFG_CONTROL_I} = {CONN_FIELDBUS, CONN_NONE, CONN_FIELDBUS,
            CONN_LOCAL};
        repeat (12) @(posedge MCLK_I);
        ARST_N_I <= 1'b1;
        t_startup();
        t_prog();
        t_save();
        t_trig();
        t_error();
        t_send();
        close_out();
    end
    // Whole run is a few hundred cycles; this bounds a hang
    initial begin
        #200000;
        failures++;
        $display("Error watchdog expected finish seen hang");
        close_out();
    end
endmodule : reader_control_status_port_test
